//--- pkg/servo_cfg_defines.svh
`ifndef SERVO_CFG_DEFINES_SVH
`define SERVO_CFG_DEFINES_SVH
// Command codes
`define OP_EXT_GAIN 8'h46
`define OP_DONE_OFF 8'hAB
`define OP_DONE_ON 8'hFB
`define OP_DEBOUNCE 8'hFC
`define OP_DIRECTION 8'hB8
`define OP_DUAL_LOOP 8'hF3
// Command lengths in words
`define LEN_EXT_GAIN 4'h9
`define LEN_DEBOUNCE 4'h3
`define LEN_DIRECTION 4'h2
// Limits and defaults
`define GAIN_MAX 16'h7FFF
`define FILT_MAX 16'h7FFF
`define FILT_DEFAULT 16'h0053
`define NUM_LINES 7
// Timing
`define TICK_US 120
`define CLK_MHZ 100
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_STATE 8'h0C
`define REG_GAIN0 8'h10
`define REG_FILT0 8'h30
`define REG_TARGET 8'h4C
// Control bits
`define CTRL_STD_FILT 0
`define CTRL_LOOP_CLOSED 1
`define CTRL_ECHO_ON 2
`define CTRL_SSI_DUAL 3
// Status event bits
`define EV_CMD_DONE 0
`define EV_SEQ_ERR 1
`define EV_BAD_CMD 2
`define EV_INPUT_CHG 3
`define EV_WIDTH 4
`endif

//--- pkg/servo_cfg_pkg.sv
package servo_cfg_pkg;
   typedef enum logic [2:0] {
      PS_IDLE = 3'b001,
      PS_ARGS = 3'b010,
      PS_EXEC = 3'b100
   } parse_state_type;
   typedef logic [15:0] word_type;
endpackage

//--- pkg/debounce_if.sv
`timescale 1ns/1ps
interface debounce_if;
   logic tick;
   logic wrEn;
   logic [2:0] wrSel;
   logic [15:0] wrConst;
   logic [6:0] rawIn;
   logic [6:0] cleanIn;
   logic [111:0] constFlat;
   modport ctrl (output tick, output wrEn, output wrSel, output wrConst, output rawIn,
      input cleanIn, input constFlat);
   modport filt (input tick, input wrEn, input wrSel, input wrConst, input rawIn,
      output cleanIn, output constFlat);
endinterface

//--- core/input_debounce.sv
// Purpose: per-line up/down debounce filters for seven digital inputs
// Assumes: tick is a one-cycle pulse every 120 us
// Notes: selector 0 writes every line, 1..7 one line
`timescale 1ns/1ps
`include "servo_cfg_defines.svh"
module input_debounce
   import servo_cfg_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Control side
   debounce_if.filt dbi
);
   logic [15:0] limit_ff [`NUM_LINES];
   logic [15:0] count_ff [`NUM_LINES];
   logic [6:0] state_ff;

   assign dbi.cleanIn = state_ff;

   genvar g;
   generate
      for (g = 0; g < `NUM_LINES; g++) begin : gLine
         wire hit = dbi.wrEn && (dbi.wrSel == 3'h0 || dbi.wrSel == 3'(g + 1)); // R7
         wire differs = dbi.rawIn[g] != state_ff[g];
         wire reached = (count_ff[g] + 16'h0001) >= limit_ff[g];
         assign dbi.constFlat[g*16 +: 16] = limit_ff[g];
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               limit_ff[g] <= `FILT_DEFAULT; // R8
               count_ff[g] <= 16'h0000;
               state_ff[g] <= 1'b0;
            end else begin
               if (hit) begin
                  limit_ff[g] <= dbi.wrConst;
               end
               if (dbi.tick) begin
                  if (differs && (reached || limit_ff[g] == 16'h0000)) begin
                     state_ff[g] <= dbi.rawIn[g]; // R9
                     count_ff[g] <= 16'h0000;
                  end else if (differs) begin
                     count_ff[g] <= count_ff[g] + 16'h0001; // R9 R16
                  end else if (count_ff[g] != 16'h0000) begin
                     count_ff[g] <= count_ff[g] - 16'h0001; // R9 R16
                  end
               end else if (count_ff[g] > limit_ff[g]) begin
                  count_ff[g] <= limit_ff[g]; // R16
               end
            end
         end
      end
   endgenerate
endmodule

//--- core/servo_cfg_handler.sv
// Purpose: servo configuration command handler with register port
// Assumes: one command word per cmdValid pulse, cmdStart marks the opcode word
// Notes: opcode sits in the low byte of the first word
// What this block does
// (R1) Code 70: nine words, eight gains, clamp 32767
// (R2) Standard filters force second acceleration gain zero
// (R3) Code 171 stops driving done on line 1
// (R4) Done indication inactive after power-up
// (R5) Encoder echo off restores normal line function
// (R6) Code 252: three words, selector then constant
// (R7) Selector 0 all lines, 1..7 one line
// (R8) Constants in 120 us ticks, default 83
// (R9) Up/down counter decides debounced state
// (R10) Code 184 sets direction, 1 reverses sign
// (R11) Direction after loop closed raises sequence error
// (R12) Code 243: position feedback from secondary encoder
// (R13) Dual loop error checks use secondary position
// (R14) Dual loop entry loads target from secondary
// (R15) SSI source selected becomes dual feedback
// (R16) Debounce counter saturates at zero and constant
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "servo_cfg_defines.svh"
module servo_cfg_handler
   import servo_cfg_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYCLES
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Command link
   input wire logic cmdValid,
   input wire logic cmdStart,
   input wire logic [15:0] cmdWord,
   output logic cmdAck,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output logic irq,
   // Servo status and encoders
   input wire logic servoIdle,
   input wire logic encA,
   input wire logic encB,
   input wire logic encIdx,
   input wire logic [31:0] primaryPos,
   input wire logic [31:0] secondaryPos,
   input wire logic [31:0] ssiPos,
   // Digital I/O lines 1..3 and filtered inputs
   input wire logic [6:0] rawInputs,
   output logic [2:0] ioOut,
   output logic [2:0] ioOe,
   output logic [6:0] cleanInputs,
   // Loop configuration
   output logic [127:0] loopGains,
   output logic dirReverse,
   output logic dualLoop,
   output logic [31:0] feedbackPos,
   output logic [31:0] limitCheckPos,
   output logic [31:0] velFeedbackPos,
   output logic [31:0] targetPos,
   output logic targetLoad
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] clampGain(input logic [15:0] v);
      clampGain = (v > `GAIN_MAX) ? `GAIN_MAX : v;
   endfunction

   function automatic logic [3:0] cmdLength(input logic [7:0] op);
      case (op)
         `OP_EXT_GAIN: cmdLength = `LEN_EXT_GAIN;
         `OP_DEBOUNCE: cmdLength = `LEN_DEBOUNCE;
         `OP_DIRECTION: cmdLength = `LEN_DIRECTION;
         `OP_DONE_OFF, `OP_DONE_ON, `OP_DUAL_LOOP: cmdLength = 4'h1;
         default: cmdLength = 4'h0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   parse_state_type state_ff, nxt_state;
   logic [7:0] opcode_ff;
   logic [3:0] need_ff;
   logic [3:0] got_ff;
   word_type args_ff [8];
   logic [15:0] gains_ff [8];
   logic [3:0] ctrl_ff;
   logic [`EV_WIDTH-1:0] status_ff;
   logic [`EV_WIDTH-1:0] mask_ff;
   logic doneEn_ff;
   logic dir_ff;
   logic dual_ff;
   logic ssiSel_ff;
   logic [31:0] target_ff;
   logic targetLoad_ff;
   logic ack_ff;
   logic irq_ff;
   logic [31:0] rdata_ff;
   logic [2:0] ioOut_ff;
   logic [2:0] ioOe_ff;
   logic [6:0] clean_ff;
   logic [127:0] gainsOut_ff;
   logic [31:0] fb_ff;
   logic [31:0] chk_ff;
   logic [31:0] vel_ff;
   logic [15:0] tickCnt_ff;
   logic tick_ff;

   debounce_if dbi ();

   input_debounce uFilt (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .dbi(dbi)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Command parsing
   wire [3:0] startLen = cmdLength(cmdWord[7:0]);
   wire startOk = cmdValid && cmdStart && startLen != 4'h0;
   wire startBad = cmdValid && cmdStart && startLen == 4'h0;
   wire argTake = state_ff == PS_ARGS && cmdValid && !cmdStart;
   wire argLast = argTake && (got_ff + 4'h1 == need_ff);
   wire exec = state_ff == PS_EXEC;
   wire execGain = exec && opcode_ff == `OP_EXT_GAIN;
   wire execFilt = exec && opcode_ff == `OP_DEBOUNCE;
   wire execDir = exec && opcode_ff == `OP_DIRECTION;
   wire execDual = exec && opcode_ff == `OP_DUAL_LOOP;
   wire execDoneOff = exec && opcode_ff == `OP_DONE_OFF;
   wire execDoneOn = exec && opcode_ff == `OP_DONE_ON;
   wire loopClosed = ctrl_ff[`CTRL_LOOP_CLOSED];
   wire dirSeqErr = execDir && loopClosed; // R11
   wire filtSelOk = args_ff[0] <= 16'h0007;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         PS_IDLE: begin
            if (startOk) begin
               nxt_state = (startLen == 4'h1) ? PS_EXEC : PS_ARGS;
            end
         end
         PS_ARGS: begin
            if (cmdValid && cmdStart) begin
               nxt_state = PS_IDLE;
            end else if (argLast) begin
               nxt_state = PS_EXEC;
            end
         end
         PS_EXEC: nxt_state = PS_IDLE;
         default: nxt_state = PS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= PS_IDLE;
         opcode_ff <= 8'h00;
         need_ff <= 4'h0;
         got_ff <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == PS_IDLE && startOk) begin
            opcode_ff <= cmdWord[7:0];
            need_ff <= startLen - 4'h1; // R1 R6
            got_ff <= 4'h0;
         end else if (argTake) begin
            got_ff <= got_ff + 4'h1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (argTake) begin
         args_ff[got_ff[2:0]] <= cmdWord;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gains, effective second acceleration gain
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 8; i++) begin
            gains_ff[i] <= 16'h0000;
         end
      end else if (execGain) begin
         for (int i = 0; i < 8; i++) begin
            gains_ff[i] <= clampGain(args_ff[i]); // R1
         end
      end
   end

   logic [127:0] gainsEff;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         gainsEff[i*16 +: 16] = gains_ff[i];
      end
      if (ctrl_ff[`CTRL_STD_FILT]) begin
         gainsEff[4*16 +: 16] = 16'h0000; // R2
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode flags, done and dual loop
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         doneEn_ff <= 1'b0; // R4
         dir_ff <= 1'b0; // R10
         dual_ff <= 1'b0;
         ssiSel_ff <= 1'b0;
         target_ff <= 32'h0000_0000;
         targetLoad_ff <= 1'b0;
      end else begin
         if (execDoneOff) begin
            doneEn_ff <= 1'b0; // R3
         end else if (execDoneOn) begin
            doneEn_ff <= 1'b1;
         end
         if (execDir && !loopClosed) begin
            dir_ff <= args_ff[0] == 16'h0001; // R10
         end
         if (execDual && !dual_ff) begin
            dual_ff <= 1'b1; // R12
            ssiSel_ff <= ctrl_ff[`CTRL_SSI_DUAL]; // R15
            target_ff <= ctrl_ff[`CTRL_SSI_DUAL] ? ssiPos : secondaryPos; // R14
         end
         targetLoad_ff <= execDual && !dual_ff;
      end
   end

   wire [31:0] secSrc = ssiSel_ff ? ssiPos : secondaryPos; // R15
   wire doneLevel = doneEn_ff && servoIdle;
   wire echoOn = ctrl_ff[`CTRL_ECHO_ON];
   wire [2:0] nxt_ioOut = echoOn ? {encIdx, encB, encA} : {2'b00, doneLevel};
   wire [2:0] nxt_ioOe = echoOn ? 3'b111 : {2'b00, doneEn_ff}; // R3 R5

   ////////////////////////////////////////////////////////////////////////////
   // Tick generator and filter control
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tickCnt_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= tickCnt_ff == 16'(TICK_CYCLES - 1); // R8
         tickCnt_ff <= (tickCnt_ff == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tickCnt_ff + 16'h0001;
      end
   end

   assign dbi.tick = tick_ff;
   assign dbi.wrEn = execFilt && filtSelOk; // R6 R7
   assign dbi.wrSel = args_ff[0][2:0];
   assign dbi.wrConst = (args_ff[1] > `FILT_MAX) ? `FILT_MAX : args_ff[1]; // R8
   assign dbi.rawIn = rawInputs;

   ////////////////////////////////////////////////////////////////////////////
   // Registers and events
   wire [`EV_WIDTH-1:0] events = {dbi.cleanIn != clean_ff, startBad || (exec && execFilt && !filtSelOk),
      dirSeqErr, exec};
   wire wrCtrl = regWr && regAddr == `REG_CTRL;
   wire wrStatus = regWr && regAddr == `REG_STATUS;
   wire wrMask = regWr && regAddr == `REG_MASK;
   wire [3:0] gainIdx = 4'((regAddr - `REG_GAIN0) >> 2);
   wire [3:0] filtIdx = 4'((regAddr - `REG_FILT0) >> 2);
   wire inGain = regAddr >= `REG_GAIN0 && regAddr < `REG_FILT0 && regAddr[1:0] == 2'b00;
   wire inFilt = regAddr >= `REG_FILT0 && regAddr < `REG_TARGET && regAddr[1:0] == 2'b00;
   wire [31:0] stateWord = {21'h0, clean_ff, ssiSel_ff, dual_ff, dir_ff, doneEn_ff};

   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0000_0000;
      if (regAddr == `REG_CTRL) begin
         rdMux = {28'h0, ctrl_ff};
      end else if (regAddr == `REG_STATUS) begin
         rdMux = {28'h0, status_ff};
      end else if (regAddr == `REG_MASK) begin
         rdMux = {28'h0, mask_ff};
      end else if (regAddr == `REG_STATE) begin
         rdMux = stateWord;
      end else if (inGain) begin
         rdMux = {16'h0, gainsEff[gainIdx[2:0]*16 +: 16]};
      end else if (inFilt) begin
         rdMux = {16'h0, dbi.constFlat[filtIdx[2:0]*16 +: 16]};
      end else if (regAddr == `REG_TARGET) begin
         rdMux = target_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff <= 4'h0;
         status_ff <= '0;
         mask_ff <= '0;
         rdata_ff <= 32'h0000_0000;
         irq_ff <= 1'b0;
         ack_ff <= 1'b0;
      end else begin
         if (wrCtrl) begin
            ctrl_ff <= regWdata[3:0]; // R5
         end
         if (wrMask) begin
            mask_ff <= regWdata[`EV_WIDTH-1:0];
         end
         status_ff <= (status_ff & ~(wrStatus ? regWdata[`EV_WIDTH-1:0] : '0)) | events;
         irq_ff <= |(((status_ff & ~(wrStatus ? regWdata[`EV_WIDTH-1:0] : '0)) | events) & mask_ff);
         rdata_ff <= regRd ? rdMux : 32'h0000_0000;
         ack_ff <= exec;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ioOut_ff <= 3'b000;
         ioOe_ff <= 3'b000; // R4
         clean_ff <= 7'h00;
         gainsOut_ff <= '0;
         fb_ff <= 32'h0000_0000;
         chk_ff <= 32'h0000_0000;
         vel_ff <= 32'h0000_0000;
      end else begin
         ioOut_ff <= nxt_ioOut;
         ioOe_ff <= nxt_ioOe;
         clean_ff <= dbi.cleanIn;
         gainsOut_ff <= gainsEff;
         fb_ff <= dual_ff ? secSrc : primaryPos; // R12
         chk_ff <= dual_ff ? secSrc : primaryPos; // R13
         vel_ff <= primaryPos; // R12
      end
   end

   assign cmdAck = ack_ff;
   assign regRdata = rdata_ff;
   assign irq = irq_ff;
   assign ioOut = ioOut_ff;
   assign ioOe = ioOe_ff;
   assign cleanInputs = clean_ff;
   assign loopGains = gainsOut_ff;
   assign dirReverse = dir_ff;
   assign dualLoop = dual_ff;
   assign feedbackPos = fb_ff;
   assign limitCheckPos = chk_ff;
   assign velFeedbackPos = vel_ff;
   assign targetPos = target_ff;
   assign targetLoad = targetLoad_ff;
endmodule

//--- bench/servo_cfg_chk.sv
// Purpose: port assertions for the servo configuration handler
// Assumes: control register writes land on the next edge
// Notes: bound to every handler instance
`timescale 1ns/1ps
module servo_cfg_chk
   import servo_cfg_pkg::*;
#(
   parameter int TICK_CYCLES = 12000
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Command and registers
   input wire logic cmdValid,
   input wire logic cmdStart,
   input wire logic [15:0] cmdWord,
   input wire logic cmdAck,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   // Positions in
   input wire logic [31:0] primaryPos,
   input wire logic [31:0] secondaryPos,
   input wire logic [31:0] ssiPos,
   // Outputs
   input wire logic [2:0] ioOe,
   input wire logic [127:0] loopGains,
   input wire logic dirReverse,
   input wire logic dualLoop,
   input wire logic [31:0] feedbackPos,
   input wire logic [31:0] limitCheckPos,
   input wire logic [31:0] velFeedbackPos,
   input wire logic [31:0] targetPos,
   input wire logic targetLoad
);
   logic [3:0] ctrlSeen_ff;
   logic [7:0] opSeen_ff;
   logic ssiEntry_ff;
   wire [3:0] nxt_ctrlSeen = (regWr && regAddr == 8'h00) ? regWdata[3:0] : ctrlSeen_ff;
   wire [7:0] nxt_opSeen = (cmdValid && cmdStart) ? cmdWord[7:0] : opSeen_ff;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrlSeen_ff <= 4'h0;
         opSeen_ff <= 8'h00;
         ssiEntry_ff <= 1'b0;
      end else begin
         ctrlSeen_ff <= nxt_ctrlSeen;
         opSeen_ff <= nxt_opSeen;
         // Source choice frozen once in dual loop
         ssiEntry_ff <= dualLoop ? ssiEntry_ff : ctrlSeen_ff[3];
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_doneOffAck;
      cmdAck && opSeen_ff == 8'hAB && !ctrlSeen_ff[2];
   endsequence
   sequence s_doneQuiet;
      ##1 (!ioOe[0]) [*3];
   endsequence
   property p_secondary(logic [31:0] pos);
      dualLoop && $past(dualLoop) |-> pos == (ssiEntry_ff ? $past(ssiPos) : $past(secondaryPos));
   endproperty
   a_done_reset: assert property ($rose(rstn) |-> !ioOe[0])
      else $error("done driven after reset");
   a_gain_clamp: assert property ((loopGains & {8{16'h8000}}) == 128'h0)
      else $error("gain above limit");
   a_accel_b_zero: assert property (ctrlSeen_ff[0] && $past(ctrlSeen_ff[0]) |-> loopGains[79:64] == 16'h0000)
      else $error("second accel gain not zero");
   a_dir_locked: assert property (ctrlSeen_ff[1] && $past(ctrlSeen_ff[1]) && $past(ctrlSeen_ff[1], 2)
      && $past(ctrlSeen_ff[1], 3) |-> $stable(dirReverse))
      else $error("direction changed with loop closed");
   a_done_off: assert property (s_doneOffAck |-> s_doneQuiet)
      else $error("done still driven");
   a_echo_off: assert property (!ctrlSeen_ff[2] && !$past(ctrlSeen_ff[2]) && !$past(ctrlSeen_ff[2], 2)
      |-> ioOe[2:1] == 2'b00)
      else $error("echo lines still driven");
   a_pos_secondary: assert property (p_secondary(feedbackPos))
      else $error("feedback not secondary");
   a_limit_secondary: assert property (p_secondary(limitCheckPos))
      else $error("limit check not secondary");
   a_vel_primary: assert property (dualLoop && $past(dualLoop) |-> velFeedbackPos == $past(primaryPos))
      else $error("velocity not primary");
   a_entry_load: assert property ($rose(dualLoop) |-> targetLoad
      && targetPos == (ssiEntry_ff ? $past(ssiPos) : $past(secondaryPos)))
      else $error("target not loaded on entry");
endmodule
bind servo_cfg_handler servo_cfg_chk #(.TICK_CYCLES(TICK_CYCLES)) i_servo_cfg_chk (
   .ref_clk(ref_clk), .rstn(rstn), .cmdValid(cmdValid), .cmdStart(cmdStart), .cmdWord(cmdWord),
   .cmdAck(cmdAck), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .primaryPos(primaryPos),
   .secondaryPos(secondaryPos), .ssiPos(ssiPos), .ioOe(ioOe), .loopGains(loopGains), .dirReverse(dirReverse),
   .dualLoop(dualLoop), .feedbackPos(feedbackPos), .limitCheckPos(limitCheckPos),
   .velFeedbackPos(velFeedbackPos), .targetPos(targetPos), .targetLoad(targetLoad));

//--- bench/host_cmd_model.sv
// Purpose: host that sends configuration commands word by word
// Assumes: opcode first, arguments follow back to back
// Notes: idle word shows the inverse of the last word
`timescale 1ns/1ps
module host_cmd_model
   import servo_cfg_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Command link
   output logic cmdValid,
   output logic cmdStart,
   output word_type cmdWord,
   input wire logic cmdAck
);
   initial begin
      cmdValid = 1'b0;
      cmdStart = 1'b0;
      cmdWord = 16'h0000;
   end
   task automatic send(input word_type w [9], input int n, output bit acked);
      int k;
      acked = 1'b0;
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         cmdValid <= 1'b1;
         cmdStart <= (i == 0);
         cmdWord <= w[i];
      end
      @(posedge ref_clk);
      cmdValid <= 1'b0;
      cmdStart <= 1'b0;
      cmdWord <= ~w[n-1];
      for (k = 0; k < 6 && !acked; k++) begin
         @(posedge ref_clk);
         acked = cmdAck;
      end
   endtask
endmodule

//--- bench/testbench.sv
// Purpose: self-checking bench for the servo configuration handler
// Assumes: short tick of 4 clocks
// Notes: one task per scenario
`timescale 1ns/1ps
module testbench
   import servo_cfg_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic cmdValid, cmdStart, cmdAck, irq, dirReverse, dualLoop, targetLoad;
   word_type cmdWord;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic servoIdle = 1'b1;
   logic encA = 1'b1;
   logic encB = 1'b0;
   logic encIdx = 1'b1;
   logic [31:0] primaryPos = 32'h0000_1111;
   logic [31:0] secondaryPos = 32'h0000_2222;
   logic [31:0] ssiPos = 32'h0000_3333;
   logic [6:0] rawInputs = 7'h00;
   logic [6:0] cleanInputs;
   logic [2:0] ioOut, ioOe;
   logic [127:0] loopGains;
   logic [31:0] regRdata, feedbackPos, limitCheckPos, velFeedbackPos, targetPos, rv;
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;
   word_type w [9];
   servo_cfg_handler #(.TICK_CYCLES(4)) i_servo_cfg_handler (.ref_clk(ref_clk), .rstn(rstn),
      .cmdValid(cmdValid), .cmdStart(cmdStart), .cmdWord(cmdWord), .cmdAck(cmdAck), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
      .servoIdle(servoIdle), .encA(encA), .encB(encB), .encIdx(encIdx), .primaryPos(primaryPos),
      .secondaryPos(secondaryPos), .ssiPos(ssiPos), .rawInputs(rawInputs), .ioOut(ioOut), .ioOe(ioOe),
      .cleanInputs(cleanInputs), .loopGains(loopGains), .dirReverse(dirReverse), .dualLoop(dualLoop),
      .feedbackPos(feedbackPos), .limitCheckPos(limitCheckPos), .velFeedbackPos(velFeedbackPos),
      .targetPos(targetPos), .targetLoad(targetLoad));
   host_cmd_model i_host_cmd_model (.ref_clk(ref_clk), .cmdValid(cmdValid), .cmdStart(cmdStart),
      .cmdWord(cmdWord), .cmdAck(cmdAck));
   always #5 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic settle;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic do_reset;
      @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      @(negedge ref_clk);
      d = regRdata;
   endtask
   task automatic cmd(input int n, input bit wantAck);
      bit ok;
      i_host_cmd_model.send(w, n, ok);
      if (wantAck)
         chk("cmdAck", ok, 1);
      settle();
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk("ioOe", ioOe, 0);
      rd(8'h30, rv);
      chk("filtDefault", rv, 32'h53);
      rd(8'hF0, rv);
      chk("unmapped", rv, 0);
      w[0] = 16'h0012;
      cmd(1, 0);
      rd(8'h04, rv);
      chk("badOp", rv[2], 1);
      wr(8'h04, 32'h4);
      $display("test reset done");
   endtask
   task automatic t_gains;
      w = '{16'h0046, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h7FFF, 16'hFFFF};
      cmd(9, 1);
      for (int i = 0; i < 7; i++) begin
         chk("gain", loopGains[16*i +: 16], w[i+1]);
      end
      chk("gainClamp", loopGains[127:112], 32'h7FFF);
      wr(8'h00, 32'h1);
      settle();
      chk("accelBZero", loopGains[79:64], 0);
      chk("accelA", loopGains[63:48], 32'h4);
      wr(8'h00, 32'h0);
      $display("test gains done");
   endtask
   task automatic t_done;
      w[0] = 16'h00FB;
      cmd(1, 1);
      chk("doneOe", ioOe[0], 1);
      chk("doneIdle", ioOut[0], 1);
      @(posedge ref_clk);
      servoIdle <= 1'b0;
      settle();
      chk("doneBusy", ioOut[0], 0);
      w[0] = 16'h00AB;
      cmd(1, 1);
      chk("doneOff", ioOe[0], 0);
      $display("test done line done");
   endtask
   task automatic t_echo;
      wr(8'h00, 32'h4);
      settle();
      chk("echoOe", ioOe, 32'h7);
      chk("echoOut", ioOut, 32'h5);
      wr(8'h00, 32'h0);
      settle();
      chk("echoOff", ioOe, 0);
      $display("test echo done");
   endtask
   task automatic t_filter;
      w[0] = 16'h00FC;
      w[1] = 16'h0003;
      w[2] = 16'hFFFF;
      cmd(3, 1);
      rd(8'h38, rv);
      chk("filtOne", rv, 32'h7FFF);
      rd(8'h34, rv);
      chk("filtOther", rv, 32'h53);
      w[1] = 16'h0000;
      w[2] = 16'h0008;
      cmd(3, 1);
      for (int i = 0; i < 7; i++) begin
         rd(8'h30 + 8'(4 * i), rv);
         chk("filtAll", rv, 32'h8);
      end
      w[1] = 16'h0009;
      cmd(3, 0);
      rd(8'h04, rv);
      chk("badSel", rv[2], 1);
      rd(8'h30, rv);
      chk("filtKept", rv, 32'h8);
      @(posedge ref_clk);
      rawInputs <= 7'h01;
      repeat (28) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("early", cleanInputs[0], 0);
      @(posedge ref_clk);
      rawInputs <= 7'h00;
      repeat (4) @(posedge ref_clk);
      rawInputs <= 7'h01;
      repeat (24) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("upDown", cleanInputs[0], 1);
      $display("test filter done");
   endtask
   task automatic t_dir;
      wr(8'h04, 32'hF);
      w[0] = 16'h00B8;
      w[1] = 16'h0001;
      cmd(2, 1);
      chk("dirRev", dirReverse, 1);
      w[1] = 16'h0000;
      cmd(2, 1);
      chk("dirNorm", dirReverse, 0);
      wr(8'h00, 32'h2);
      w[1] = 16'h0001;
      cmd(2, 0);
      chk("dirLocked", dirReverse, 0);
      rd(8'h04, rv);
      chk("seqErr", rv[1], 1);
      chk("irqMasked", irq, 0);
      wr(8'h08, 32'h2);
      settle();
      chk("irqOn", irq, 1);
      wr(8'h04, 32'h2);
      settle();
      chk("irqOff", irq, 0);
      $display("test direction done");
   endtask
   task automatic t_dual;
      wr(8'h00, 32'h8);
      w[0] = 16'h00F3;
      cmd(1, 1);
      chk("ssiTarget", targetPos, ssiPos);
      chk("ssiFeed", feedbackPos, ssiPos);
      do_reset();
      cmd(1, 1);
      chk("dual", dualLoop, 1);
      chk("target", targetPos, secondaryPos);
      chk("feed", feedbackPos, secondaryPos);
      chk("limit", limitCheckPos, secondaryPos);
      chk("vel", velFeedbackPos, primaryPos);
      rd(8'h4C, rv);
      chk("targetReg", rv, secondaryPos);
      rd(8'h0C, rv);
      chk("stateReg", rv, 32'h4);
      $display("test dual loop done");
   endtask
   initial begin
      do_reset();
      t_reset();
      t_gains();
      t_done();
      t_echo();
      t_filter();
      t_dir();
      t_dual();
      tally_and_finish();
   end
endmodule
